// >>> shared/rgevm_defs.vh
// Behaviour
// [RQ1] mask register at 0x04: bit 1 masks its event, bit 0 unmasks it
// [RQ2] mask register resets to 0x13, with undervoltage and thermal shutdown unmasked
// [RQ3] read-only status shows live undervoltage and 165/140/120 degree conditions
// [RQ4] enable register 0x06 even bits enable outputs 1-4, ORed with assigned inputs
// [RQ5] enable register odd bits put outputs 1-4 into low power mode
// [RQ6] bit 7 of 0x07 selects a 1 ms or 2 ms delay step
// [RQ7] five-bit startup delays at 0x07-0x09 for outputs 2-4, zero means none
// [RQ8] startup delay counts from enable pin or global enable being asserted
// [RQ9] system event flags latch in read-to-clear register at 0x03
// [RQ10] only unmasked latched events drive the interrupt source and request
`ifndef RGEVM_DEFS_VH
`define RGEVM_DEFS_VH

`define RGEVM_ADDR_W 8
`define RGEVM_DATA_W 8

`define RGEVM_OFS_EVENT 8'h03
`define RGEVM_OFS_MASK 8'h04
`define RGEVM_OFS_STATUS 8'h05
`define RGEVM_OFS_ENABLE 8'h06
`define RGEVM_OFS_DLY2 8'h07
`define RGEVM_OFS_DLY3 8'h08
`define RGEVM_OFS_DLY4 8'h09

`define RGEVM_MASK_RESET 5'h13
`define RGEVM_ENABLE_RESET 8'h00
`define RGEVM_DLY_RESET 5'h00
`define RGEVM_STEP_RESET 1'h0
`define RGEVM_READ_IDLE 8'h00

// event bit positions, shared by flag latch and mask
`define RGEVM_EV_WATCHDOG 4
`define RGEVM_EV_UNDERVOLT 3
`define RGEVM_EV_TSHUTDOWN 2
`define RGEVM_EV_HOT_HIGH 1
`define RGEVM_EV_HOT_LOW 0
`define RGEVM_EV_W 5
`define RGEVM_STAT_W 4

// enable register layout: output n enable at 2n, low power at 2n+1
`define RGEVM_OUTPUTS 4
`define RGEVM_STEP_SEL_BIT 7
`define RGEVM_DLY_MSB 4
`define RGEVM_DLY_W 5

// timing
`define RGEVM_CLK_PERIOD_NS 8
`define RGEVM_STEP_SHORT_NS 1000000
`define RGEVM_STEP_LONG_NS 2000000
`define RGEVM_CNT_W 18

`endif

// >>> hdl/rgevm_startup_delay.v
`include "rgevm_defs.vh"

module rgevm_startup_delay #(
  parameter CNT_W = `RGEVM_CNT_W
) (
  input wire mclk,
  input wire reset,
  input wire startRequest,
  input wire [`RGEVM_DLY_W-1:0] delaySteps,
  input wire [CNT_W-1:0] stepCycles,
  output wire outputRun
);

  localparam ST_IDLE = 2'd0;
  localparam ST_WAIT = 2'd1;
  localparam ST_RUN = 2'd2;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [CNT_W-1:0] cycle_reg;
  reg [CNT_W-1:0] cycle_next;
  reg [`RGEVM_DLY_W-1:0] step_reg;
  reg [`RGEVM_DLY_W-1:0] step_next;
  wire stepDone;

  assign stepDone = (cycle_reg >= stepCycles - {{(CNT_W-1){1'b0}}, 1'b1});

  // [RQ8] delay from assertion
  always @* begin
    state_next = state_reg;
    cycle_next = cycle_reg;
    step_next = step_reg;
    case (state_reg)
      ST_IDLE: begin
        cycle_next = {CNT_W{1'b0}};
        step_next = {`RGEVM_DLY_W{1'b0}};
        if (startRequest) begin
          // [RQ7] zero means none
          if (delaySteps == {`RGEVM_DLY_W{1'b0}}) begin
            state_next = ST_RUN;
          end else begin
            state_next = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        if (!startRequest) begin
          state_next = ST_IDLE;
        end else if (stepDone) begin
          cycle_next = {CNT_W{1'b0}};
          step_next = step_reg + 1'b1;
          // compare >= so a delay shortened mid-wait cannot overshoot
          if (step_reg + 1'b1 >= delaySteps) begin
            state_next = ST_RUN;
          end
        end else begin
          cycle_next = cycle_reg + 1'b1;
        end
      end
      ST_RUN: begin
        if (!startRequest) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      cycle_reg <= {CNT_W{1'b0}};
      step_reg <= {`RGEVM_DLY_W{1'b0}};
    end else begin
      state_reg <= state_next;
      cycle_reg <= cycle_next;
      step_reg <= step_next;
    end
  end

  assign outputRun = (state_reg == ST_RUN);

endmodule // rgevm_startup_delay

// >>> hdl/rgevm_regs.v
`include "rgevm_defs.vh"

module rgevm_regs #(
  parameter CNT_W = `RGEVM_CNT_W,
  parameter STEP_SHORT_CYCLES = `RGEVM_STEP_SHORT_NS / `RGEVM_CLK_PERIOD_NS,
  parameter STEP_LONG_CYCLES = `RGEVM_STEP_LONG_NS / `RGEVM_CLK_PERIOD_NS
) (
  input wire mclk,
  input wire reset,
  input wire [`RGEVM_ADDR_W-1:0] regAddr,
  input wire [`RGEVM_DATA_W-1:0] regWrData,
  input wire regWrite,
  input wire regRead,
  output reg [`RGEVM_DATA_W-1:0] regRdData,
  input wire watchdogEvent,
  input wire undervoltageFlag,
  input wire thermalShutdownFlag,
  input wire hotWarningHighFlag,
  input wire hotWarningLowFlag,
  input wire globalEnable,
  input wire [`RGEVM_OUTPUTS-1:0] generalPurposeInput,
  output wire systemEventPending,
  output wire systemIrqN,
  output wire [`RGEVM_OUTPUTS-1:0] outputEnable,
  output wire [`RGEVM_OUTPUTS-1:0] outputLowPower,
  output wire [`RGEVM_OUTPUTS-1:0] outputRun
);

  localparam [CNT_W-1:0] STEP_SHORT = STEP_SHORT_CYCLES[CNT_W-1:0];
  localparam [CNT_W-1:0] STEP_LONG = STEP_LONG_CYCLES[CNT_W-1:0];

  reg [`RGEVM_EV_W-1:0] mask_reg;
  reg [`RGEVM_EV_W-1:0] event_reg;
  reg [`RGEVM_EV_W-1:0] event_next;
  reg [`RGEVM_DATA_W-1:0] enable_reg;
  reg step_reg;
  reg [`RGEVM_DLY_W-1:0] dly2_reg;
  reg [`RGEVM_DLY_W-1:0] dly3_reg;
  reg [`RGEVM_DLY_W-1:0] dly4_reg;
  reg [`RGEVM_STAT_W-1:0] statPrev_reg;
  reg [`RGEVM_DATA_W-1:0] readMux;

  wire [`RGEVM_STAT_W-1:0] liveStatus;
  wire [`RGEVM_EV_W-1:0] eventDetect;
  wire [`RGEVM_EV_W-1:0] unmaskedEvents;
  wire [CNT_W-1:0] stepCycles;
  wire [`RGEVM_DLY_W*`RGEVM_OUTPUTS-1:0] delayBus;
  wire wrMask;
  wire wrEnable;
  wire wrDly2;
  wire wrDly3;
  wire wrDly4;
  wire rdEvent;

  assign wrMask = regWrite && (regAddr == `RGEVM_OFS_MASK);
  assign wrEnable = regWrite && (regAddr == `RGEVM_OFS_ENABLE);
  assign wrDly2 = regWrite && (regAddr == `RGEVM_OFS_DLY2);
  assign wrDly3 = regWrite && (regAddr == `RGEVM_OFS_DLY3);
  assign wrDly4 = regWrite && (regAddr == `RGEVM_OFS_DLY4);
  assign rdEvent = regRead && (regAddr == `RGEVM_OFS_EVENT);

  // [RQ3] live condition bits
  assign liveStatus[`RGEVM_EV_UNDERVOLT] = undervoltageFlag;
  assign liveStatus[`RGEVM_EV_TSHUTDOWN] = thermalShutdownFlag;
  assign liveStatus[`RGEVM_EV_HOT_HIGH] = hotWarningHighFlag;
  assign liveStatus[`RGEVM_EV_HOT_LOW] = hotWarningLowFlag;

  // [RQ9] event on rising condition; watchdog input latched while high
  assign eventDetect[`RGEVM_EV_WATCHDOG] = watchdogEvent;
  assign eventDetect[`RGEVM_STAT_W-1:0] = liveStatus & ~statPrev_reg;

  // [RQ9] read clears, set wins
  always @* begin
    event_next = event_reg;
    if (rdEvent) begin
      event_next = {`RGEVM_EV_W{1'b0}};
    end
    event_next = event_next | eventDetect;
  end

  always @(posedge mclk) begin
    if (reset) begin
      event_reg <= {`RGEVM_EV_W{1'b0}};
      statPrev_reg <= {`RGEVM_STAT_W{1'b0}};
    end else begin
      event_reg <= event_next;
      statPrev_reg <= liveStatus;
    end
  end

  // [RQ2] mask reset value
  always @(posedge mclk) begin
    if (reset) begin
      mask_reg <= `RGEVM_MASK_RESET;
    end else if (wrMask) begin
      // [RQ1] mask write
      mask_reg <= regWrData[`RGEVM_EV_W-1:0];
    end
  end

  // [RQ10] masked events excluded
  assign unmaskedEvents = event_reg & ~mask_reg;
  assign systemEventPending = |unmaskedEvents;
  assign systemIrqN = ~systemEventPending;

  // [RQ4] enable register
  always @(posedge mclk) begin
    if (reset) begin
      enable_reg <= `RGEVM_ENABLE_RESET;
    end else if (wrEnable) begin
      enable_reg <= regWrData;
    end
  end

  // [RQ6] step select storage
  // [RQ7] delay field storage
  always @(posedge mclk) begin
    if (reset) begin
      step_reg <= `RGEVM_STEP_RESET;
      dly2_reg <= `RGEVM_DLY_RESET;
      dly3_reg <= `RGEVM_DLY_RESET;
      dly4_reg <= `RGEVM_DLY_RESET;
    end else begin
      if (wrDly2) begin
        step_reg <= regWrData[`RGEVM_STEP_SEL_BIT];
        dly2_reg <= regWrData[`RGEVM_DLY_MSB:0];
      end
      if (wrDly3) begin
        dly3_reg <= regWrData[`RGEVM_DLY_MSB:0];
      end
      if (wrDly4) begin
        dly4_reg <= regWrData[`RGEVM_DLY_MSB:0];
      end
    end
  end

  // [RQ6] step length
  assign stepCycles = step_reg ? STEP_LONG : STEP_SHORT;

  // output 1 has no delay field, so it starts at once
  assign delayBus = {dly4_reg, dly3_reg, dly2_reg, `RGEVM_DLY_RESET};

  genvar gi;
  generate
    for (gi = 0; gi < `RGEVM_OUTPUTS; gi = gi + 1) begin : gOut
      // [RQ4] register OR assigned input
      assign outputEnable[gi] = enable_reg[2*gi] | generalPurposeInput[gi];
      // [RQ5] low power bits
      assign outputLowPower[gi] = enable_reg[2*gi+1];
      // [RQ8] start after delay
      rgevm_startup_delay #(
        .CNT_W(CNT_W)
      ) uDelay (
        .mclk(mclk),
        .reset(reset),
        .startRequest(outputEnable[gi] | globalEnable),
        .delaySteps(delayBus[`RGEVM_DLY_W*gi +: `RGEVM_DLY_W]),
        .stepCycles(stepCycles),
        .outputRun(outputRun[gi])
      );
    end
  endgenerate

  // read data; unmapped addresses read as zero
  always @* begin
    readMux = `RGEVM_READ_IDLE;
    case (regAddr)
      `RGEVM_OFS_EVENT: readMux = {3'h0, event_reg};
      `RGEVM_OFS_MASK: readMux = {3'h0, mask_reg};
      // [RQ3] status readback
      `RGEVM_OFS_STATUS: readMux = {4'h0, liveStatus};
      `RGEVM_OFS_ENABLE: readMux = enable_reg;
      `RGEVM_OFS_DLY2: readMux = {step_reg, 2'h0, dly2_reg};
      `RGEVM_OFS_DLY3: readMux = {3'h0, dly3_reg};
      `RGEVM_OFS_DLY4: readMux = {3'h0, dly4_reg};
      default: readMux = `RGEVM_READ_IDLE;
    endcase
  end

  // data held until the next read
  always @(posedge mclk) begin
    if (reset) begin
      regRdData <= `RGEVM_READ_IDLE;
    end else if (regRead) begin
      regRdData <= readMux;
    end
  end

endmodule // rgevm_regs

// >>> testbench/rgevm_props.sv
module rgevm_props (
  input logic mclk,
  input logic reset,
  input logic [7:0] regAddr,
  input logic [7:0] regWrData,
  input logic regWrite,
  input logic regRead,
  input logic [7:0] regRdData,
  input logic globalEnable,
  input logic [3:0] generalPurposeInput,
  input logic systemEventPending,
  input logic systemIrqN,
  input logic [3:0] outputEnable,
  input logic [3:0] outputLowPower,
  input logic [3:0] outputRun
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_mask_wr_rd;
    regWrite && regAddr == 8'h04 ##1 regRead && !regWrite && regAddr == 8'h04;
  endsequence
  property p_mask_rd;
    s_mask_wr_rd |=> regRdData == ($past(regWrData, 2) & 8'h1f);
  endproperty
  a_mask_rd: assert property (p_mask_rd) else $error("mask readback");
  property p_status;
    regRead && regAddr == 8'h05 |=> regRdData[7:4] == 4'h0;
  endproperty
  a_status: assert property (p_status) else $error("status high bits");
  property p_en;
    logic [7:0] d;
    (regWrite && regAddr == 8'h06, d = regWrData)
      |=> outputEnable == ({d[6], d[4], d[2], d[0]} | generalPurposeInput);
  endproperty
  a_en: assert property (p_en) else $error("enable mix");
  property p_lp;
    logic [7:0] d;
    (regWrite && regAddr == 8'h06, d = regWrData) |=> outputLowPower == {d[7], d[5], d[3], d[1]};
  endproperty
  a_lp: assert property (p_lp) else $error("low power bits");
  property p_mask_all;
    regWrite && regAddr == 8'h04 && regWrData[4:0] == 5'h1f |=> !systemEventPending;
  endproperty
  a_mask_all: assert property (p_mask_all) else $error("masked pending");
  property p_irq;
    systemIrqN != systemEventPending;
  endproperty
  a_irq: assert property (p_irq) else $error("irq level");
  property p_run0;
    (outputEnable[0] || globalEnable) [*3] |-> outputRun[0];
  endproperty
  a_run0: assert property (p_run0) else $error("output 1 late");
  property p_drop;
    !(outputEnable[1] || globalEnable) |=> !outputRun[1];
  endproperty
  a_drop: assert property (p_drop) else $error("output 2 stays");
endmodule // rgevm_props

bind rgevm_regs rgevm_props props_u (.mclk, .reset, .regAddr, .regWrData, .regWrite,
  .regRead, .regRdData, .globalEnable, .generalPurposeInput, .systemEventPending,
  .systemIrqN, .outputEnable, .outputLowPower, .outputRun);

// >>> testbench/rgevm_host.sv
module rgevm_host (
  input logic mclk,
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  output logic regWrite,
  output logic regRead,
  input logic [7:0] regRdData
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrite = 0;
    regRead = 0;
  end
  // strobe stays up until the next call so back-to-back writes need no gap
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    regAddr = a;
    regWrData = d;
    regWrite = 1;
    regRead = 0;
    @(posedge mclk);
  endtask
  task idle;
    @(negedge mclk);
    regWrite = 0;
    regRead = 0;
    // released data is scrambled so stale values never look valid
    regWrData = ~regWrData;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    regAddr = a;
    regWrite = 0;
    regRead = 1;
    @(posedge mclk);
    idle();
    d = regRdData;
  endtask
endmodule // rgevm_host

// >>> testbench/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, reset, regWrite, regRead, watchdogEvent, globalEnable;
  logic undervoltageFlag, thermalShutdownFlag, hotWarningHighFlag, hotWarningLowFlag;
  logic [7:0] regAddr, regWrData, regRdData, rdv;
  logic [3:0] generalPurposeInput, outputEnable, outputLowPower, outputRun;
  logic systemEventPending, systemIrqN;
  int n_mismatch = 0;
  int n_tests = 0;
  // short steps keep the delay scenarios to a few hundred cycles
  rgevm_regs #(.STEP_SHORT_CYCLES(4), .STEP_LONG_CYCLES(8)) dut_u (.mclk, .reset, .regAddr,
    .regWrData, .regWrite, .regRead, .regRdData, .watchdogEvent, .undervoltageFlag,
    .thermalShutdownFlag, .hotWarningHighFlag, .hotWarningLowFlag, .globalEnable,
    .generalPurposeInput, .systemEventPending, .systemIrqN, .outputEnable,
    .outputLowPower, .outputRun);
  rgevm_host host_u (.mclk, .regAddr, .regWrData, .regWrite, .regRead, .regRdData);
  initial begin
    mclk = 0;
    forever #4 mclk = ~mclk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task rc(input logic [7:0] a, input logic [7:0] e);
    host_u.rd(a, rdv);
    chk(rdv, e);
  endtask
  task stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task meas(input int e0, input int e1, input int e2, input int e3);
    int t[4];
    t = '{0, 0, 0, 0};
    @(negedge mclk);
    globalEnable = 1;
    for (int k = 1; k < 140; k++) begin
      @(negedge mclk);
      for (int i = 0; i < 4; i++) if (outputRun[i] === 1'b1 && t[i] == 0) t[i] = k;
    end
    chk(t[0], e0);
    chk(t[1], e1);
    chk(t[2], e2);
    chk(t[3], e3);
    globalEnable = 0;
    @(negedge mclk);
    chk(outputRun, 4'h0);
  endtask
  initial begin
    reset = 1;
    watchdogEvent = 0;
    globalEnable = 0;
    generalPurposeInput = 4'h0;
    {undervoltageFlag, thermalShutdownFlag, hotWarningHighFlag, hotWarningLowFlag} = 4'h0;
    repeat (10) @(negedge mclk);
    reset = 0;
    rc(8'h04, 8'h13);
    rc(8'h06, 8'h00);
    for (int a = 7; a < 10; a++) rc(a[7:0], 8'h00);
    rc(8'h03, 8'h00);
    $display("reset test done");
    thermalShutdownFlag = 1;
    hotWarningLowFlag = 1;
    host_u.idle();
    chk(systemIrqN, 1'b0);
    rc(8'h05, 8'h05);
    rc(8'h03, 8'h05);
    rc(8'h03, 8'h00);
    chk(systemIrqN, 1'b1);
    {thermalShutdownFlag, hotWarningLowFlag} = 2'h0;
    host_u.wr(8'h04, 8'h1f);
    rc(8'h04, 8'h1f);
    host_u.wr(8'h05, 8'hff);
    host_u.idle();
    // flags change on the falling edge only, never in the write's sampling step
    thermalShutdownFlag = 1;
    host_u.idle();
    chk(systemIrqN, 1'b1);
    host_u.wr(8'h04, 8'h0f);
    host_u.idle();
    watchdogEvent = 1;
    host_u.idle();
    watchdogEvent = 0;
    chk(systemIrqN, 1'b0);
    rc(8'h04, 8'h0f);
    rc(8'h05, 8'h04);
    rc(8'h03, 8'h14);
    undervoltageFlag = 1;
    hotWarningHighFlag = 1;
    host_u.idle();
    chk(systemIrqN, 1'b1);
    rc(8'h05, 8'h0e);
    rc(8'h03, 8'h0a);
    {undervoltageFlag, thermalShutdownFlag, hotWarningHighFlag} = 3'h0;
    // event still high at the clearing read: the set must win
    watchdogEvent = 1;
    rc(8'h03, 8'h10);
    watchdogEvent = 0;
    rc(8'h03, 8'h10);
    rc(8'h03, 8'h00);
    $display("event test done");
    host_u.wr(8'h06, 8'h55);
    host_u.idle();
    chk({outputEnable, outputLowPower}, 8'hf0);
    host_u.wr(8'h06, 8'haa);
    host_u.idle();
    generalPurposeInput = 4'h2;
    host_u.idle();
    chk({outputEnable, outputLowPower}, 8'h2f);
    rc(8'h06, 8'haa);
    generalPurposeInput = 4'h0;
    host_u.wr(8'h06, 8'h00);
    host_u.wr(8'h07, 8'he2);
    host_u.wr(8'h08, 8'h01);
    rc(8'h07, 8'h82);
    // request seen one edge after it is driven, then N steps of the selected length
    meas(1, 17, 9, 1);
    host_u.wr(8'h07, 8'h1f);
    host_u.idle();
    meas(1, 125, 5, 1);
    $display("startup test done");
    stop_test();
  end
endmodule // tb_top
